// ==== hw/pcg_clock_gates.sv ====
// The AXI4-Lite slave port is this design's own decision.
`timescale 1ns/1ps
module pcg_clock_gates #(
  parameter int ADDR_W = 8
) (
  input  wire logic                                 clock,
  input  wire logic                                 rst_b,
  // AXI4-Lite write address channel.
  input  wire logic                                 awvalid,
  output logic                                      awready,
  input  wire logic [ADDR_W-1:0]                    awaddr,
  input  wire logic [2:0]                           awprot,
  // AXI4-Lite write data channel.
  input  wire logic                                 wvalid,
  output logic                                      wready,
  input  wire logic [31:0]                          wdata,
  input  wire logic [3:0]                           wstrb,
  // AXI4-Lite write response channel.
  output logic                                      bvalid,
  input  wire logic                                 bready,
  output logic [1:0]                                bresp,
  // AXI4-Lite read address channel.
  input  wire logic                                 arvalid,
  output logic                                      arready,
  input  wire logic [ADDR_W-1:0]                    araddr,
  input  wire logic [2:0]                           arprot,
  // AXI4-Lite read data channel.
  output logic                                      rvalid,
  input  wire logic                                 rready,
  output logic [31:0]                               rdata,
  output logic [1:0]                                rresp,
  // Gated bus clocks, indexed as the bits of their mask registers.
  output logic [pcg_pkg::BRIDGE_A_GATES-1:0]        firstBridgeClk,
  output logic [pcg_pkg::BRIDGE_B_GATES-1:0]        secondBridgeClk,
  output logic [pcg_pkg::BRIDGE_C_GATES-1:0]        thirdBridgeClk
);
  import pcg_pkg::*;

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  logic [31:0]        maskA_q, maskA_d;      // First-bridge gate mask.
  logic [31:0]        maskB_q, maskB_d;      // Second-bridge gate mask.
  logic [31:0]        maskC_q, maskC_d;      // Third-bridge gate mask.
  logic               awHeld_q, awHeld_d;    // A write address is waiting.
  logic [ADDR_W-1:0]  awAddr_q, awAddr_d;    // The waiting write address.
  logic               wHeld_q, wHeld_d;      // Write data is waiting.
  logic [31:0]        wData_q, wData_d;      // The waiting write data.
  logic [3:0]         wStrb_q, wStrb_d;      // The waiting byte strobes.
  logic               awRdy_q, awRdy_d;      // Registered awready.
  logic               wRdy_q, wRdy_d;        // Registered wready.
  logic               bValid_q, bValid_d;    // Registered bvalid.
  logic [1:0]         bResp_q, bResp_d;      // Registered bresp.
  logic               arRdy_q, arRdy_d;      // Registered arready.
  logic               rValid_q, rValid_d;    // Registered rvalid.
  logic [31:0]        rData_q, rData_d;      // Registered rdata.
  logic [1:0]         rResp_q, rResp_d;      // Registered rresp.
  logic               doWrite;               // Both halves present, slot free.

  // Protection attributes carry no meaning for these registers.
  logic               unusedProt;
  assign unusedProt = ^{awprot, arprot};

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // Merge write data into a register by byte lane, then drop bits that have
  // no gate behind them so they keep reading as zero.
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                        input logic [3:0] strb, input logic [31:0] impl);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++)
    begin
      if (strb[b])
      begin
        res[8*b +: 8] = data[8*b +: 8];
      end
    end
    return res & impl;
  endfunction

  // Word decode: the two low address bits are ignored.
  function automatic logic hit(input logic [ADDR_W-1:0] addr, input logic [7:0] ofs);
    return addr[ADDR_W-1:2] == (ADDR_W-2)'(ofs >> 2);
  endfunction

  // ----------------------------------------------------------------------
  // Next-state logic for the bus slave and the masks
  // ----------------------------------------------------------------------
  // Address and data of a write are taken in either order; the register is
  // updated one edge after both are held, and the response rises on that same edge.
  always_comb
  begin
    maskA_d  = maskA_q;
    maskB_d  = maskB_q;
    maskC_d  = maskC_q;
    awHeld_d = awHeld_q;
    awAddr_d = awAddr_q;
    wHeld_d  = wHeld_q;
    wData_d  = wData_q;
    wStrb_d  = wStrb_q;
    bValid_d = bValid_q;
    bResp_d  = bResp_q;
    rValid_d = rValid_q;
    rData_d  = rData_q;
    rResp_d  = rResp_q;
    doWrite  = awHeld_q && wHeld_q && !bValid_q;

    // Capture the write address.
    if (awvalid && awRdy_q)
    begin
      awHeld_d = 1'b1;
      awAddr_d = awaddr;
    end

    // Capture the write data.
    if (wvalid && wRdy_q)
    begin
      wHeld_d = 1'b1;
      wData_d = wdata;
      wStrb_d = wstrb;
    end

    // A taken response frees the slot.
    if (bValid_q && bready)
    begin
      bValid_d = 1'b0;
    end

    // Perform the write; each mask bit then steers its own gate.
    if (doWrite)
    begin
      awHeld_d = 1'b0;
      wHeld_d  = 1'b0;
      bValid_d = 1'b1;
      bResp_d  = RESP_OKAY;
      if (hit(awAddr_q, BRIDGE_A_MASK_OFS))
      begin
        maskA_d = merge(maskA_q, wData_q, wStrb_q, BRIDGE_A_IMPL);
      end
      else if (hit(awAddr_q, BRIDGE_B_MASK_OFS))
      begin
        maskB_d = merge(maskB_q, wData_q, wStrb_q, BRIDGE_B_IMPL);
      end
      else if (hit(awAddr_q, BRIDGE_C_MASK_OFS))
      begin
        maskC_d = merge(maskC_q, wData_q, wStrb_q, BRIDGE_C_IMPL);
      end
      else
      begin
        bResp_d = RESP_SLVERR;  // Unmapped word: nothing changes.
      end
    end

    // A taken read answer frees the read slot.
    if (rValid_q && rready)
    begin
      rValid_d = 1'b0;
    end

    // Take a read and answer on the next edge.
    if (arvalid && arRdy_q)
    begin
      rValid_d = 1'b1;
      rResp_d  = RESP_OKAY;
      if (hit(araddr, BRIDGE_A_MASK_OFS))
      begin
        rData_d = maskA_q;
      end
      else if (hit(araddr, BRIDGE_B_MASK_OFS))
      begin
        rData_d = maskB_q;
      end
      else if (hit(araddr, BRIDGE_C_MASK_OFS))
      begin
        rData_d = maskC_q;
      end
      else
      begin
        rData_d = 32'h00000000;
        rResp_d = RESP_SLVERR;
      end
    end

    // Readies drop while a request is held or its answer is pending, so one
    // write and one read at most are in flight.
    awRdy_d = !awHeld_d && !bValid_d;
    wRdy_d  = !wHeld_d && !bValid_d;
    arRdy_d = !rValid_d;
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  // Reset loads the documented masks, cut to the implemented gates.
  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      maskA_q  <= BRIDGE_A_RESET & BRIDGE_A_IMPL;
      maskB_q  <= BRIDGE_B_RESET & BRIDGE_B_IMPL;
      maskC_q  <= BRIDGE_C_RESET & BRIDGE_C_IMPL;
      awHeld_q <= 1'b0;
      awAddr_q <= '0;
      wHeld_q  <= 1'b0;
      wData_q  <= 32'h00000000;
      wStrb_q  <= 4'h0;
      awRdy_q  <= 1'b0;
      wRdy_q   <= 1'b0;
      bValid_q <= 1'b0;
      bResp_q  <= RESP_OKAY;
      arRdy_q  <= 1'b0;
      rValid_q <= 1'b0;
      rData_q  <= 32'h00000000;
      rResp_q  <= RESP_OKAY;
    end
    else
    begin
      maskA_q  <= maskA_d;
      maskB_q  <= maskB_d;
      maskC_q  <= maskC_d;
      awHeld_q <= awHeld_d;
      awAddr_q <= awAddr_d;
      wHeld_q  <= wHeld_d;
      wData_q  <= wData_d;
      wStrb_q  <= wStrb_d;
      awRdy_q  <= awRdy_d;
      wRdy_q   <= wRdy_d;
      bValid_q <= bValid_d;
      bResp_q  <= bResp_d;
      arRdy_q  <= arRdy_d;
      rValid_q <= rValid_d;
      rData_q  <= rData_d;
      rResp_q  <= rResp_d;
    end
  end

  assign awready = awRdy_q;
  assign wready  = wRdy_q;
  assign bvalid  = bValid_q;
  assign bresp   = bResp_q;
  assign arready = arRdy_q;
  assign rvalid  = rValid_q;
  assign rdata   = rData_q;
  assign rresp   = rResp_q;

  // ----------------------------------------------------------------------
  // Clock gates
  // ----------------------------------------------------------------------
  // Enables come straight from the mask flops; the gated clocks are a latch
  // and an AND, since a clock cannot be the output of a flop.
  pcg_gate_if #(.N(TOTAL_GATES)) gateBus ();

  assign gateBus.enable = {maskC_q[BRIDGE_C_GATES-1:0],
                           maskB_q[BRIDGE_B_GATES-1:0],
                           maskA_q[BRIDGE_A_GATES-1:0]};

  pcg_gate_array #(.N(TOTAL_GATES)) u_gates (
    .clock (clock),
    .gates (gateBus.gate)
  );

  assign firstBridgeClk  = gateBus.gatedClk[BRIDGE_A_GATES-1:0];
  assign secondBridgeClk = gateBus.gatedClk[BRIDGE_A_GATES +: BRIDGE_B_GATES];
  assign thirdBridgeClk  = gateBus.gatedClk[BRIDGE_A_GATES + BRIDGE_B_GATES +: BRIDGE_C_GATES];

endmodule

// ==== hw/pcg_gate_array.sv ====
`timescale 1ns/1ps
module pcg_gate_array #(
  parameter int N = 25
) (
  input wire logic  clock,
  pcg_gate_if.gate  gates
);
  import pcg_pkg::*;

  // ----------------------------------------------------------------------
  // Latch-based clock gates
  // ----------------------------------------------------------------------
  // Each enable is captured by a latch that is open only while the clock is
  // low, so a change can never cut a high phase short or start one midway.
  // A plain AND with the flop output would glitch because the flop moves
  // just after the rising edge, while the clock is high.
  // Each cell owns its latch, so no variable has more than one process writing it.
  for (genvar i = 0; i < N; i++)
  begin : g_cell
    logic enLatch;  // Enable held steady through each high phase.

    // Transparent while the clock is low, closed while it is high.
    always_latch
    begin
      if (!clock)
      begin
        enLatch <= gates.enable[i];
      end
    end

    // The gated clock only ever carries whole clock pulses.
    assign gates.gatedClk[i] = clock & enLatch;
  end

endmodule

// ==== inc/pcg_gate_if.sv ====
`timescale 1ns/1ps
// ------------------------------------------------------------------------
// Enables toward the gate cells and the gated clocks coming back.
// ------------------------------------------------------------------------
interface pcg_gate_if #(
  parameter int N = 25
);
  logic [N-1:0] enable;    // Registered gate enables, one per peripheral clock.
  logic [N-1:0] gatedClk;  // Gated bus clocks.

  modport ctrl (output enable, input gatedClk);
  modport gate (input enable, output gatedClk);
endinterface

// ==== inc/pcg_pkg.sv ====
// Operation
// - Bridge A bit 0 gates protect_ctl_zero clock
// - Bridge B bits 3..0 gate four peripheral clocks
// - Bridge B mask resets so all run
// - Bridge C bits 19..16 gate analog, touch clocks
// - Bridge C bits 15..8 gate timer counters
// - Bridge C bits 7..2 gate serial units
// - Bridge C bit 1 gates event_router clock
// - Bridge C reset runs only analog input
package pcg_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [7:0]  BRIDGE_A_MASK_OFS = 8'h18;  // First-bridge gate mask word.
  localparam logic [7:0]  BRIDGE_B_MASK_OFS = 8'h1c;  // Second-bridge gate mask word.
  localparam logic [7:0]  BRIDGE_C_MASK_OFS = 8'h20;  // Third-bridge gate mask word.

  // Reset values as loaded; unimplemented bits are then cut by the masks below.
  localparam logic [31:0] BRIDGE_A_RESET    = 32'h0000007f;
  localparam logic [31:0] BRIDGE_B_RESET    = 32'h0000007f;
  localparam logic [31:0] BRIDGE_C_RESET    = 32'h00010000;

  // Bits that hold a real gate; every other bit is tied to zero.
  localparam logic [31:0] BRIDGE_A_IMPL     = 32'h00000001;
  localparam logic [31:0] BRIDGE_B_IMPL     = 32'h0000000f;
  localparam logic [31:0] BRIDGE_C_IMPL     = 32'h000fffff;

  // ----------------------------------------------------------------------
  // Gate counts and field positions
  // ----------------------------------------------------------------------
  localparam int          BRIDGE_A_GATES    = 1;
  localparam int          BRIDGE_B_GATES    = 4;
  localparam int          BRIDGE_C_GATES    = 20;
  localparam int          TOTAL_GATES       = BRIDGE_A_GATES + BRIDGE_B_GATES + BRIDGE_C_GATES;
  localparam int          PROTECT_ZERO_BIT  = 0;   // Bridge A.
  localparam int          PIN_CTL_BIT       = 3;   // Bridge B.
  localparam int          FLASH_CTL_BIT     = 2;
  localparam int          DEBUG_UNIT_BIT    = 1;
  localparam int          PROTECT_ONE_BIT   = 0;
  localparam int          TOUCH_CTL_BIT     = 19;  // Bridge C.
  localparam int          ANALOG_OUT_BIT    = 18;
  localparam int          ANALOG_CMP_BIT    = 17;
  localparam int          ANALOG_IN_BIT     = 16;
  localparam int          TIMER_FIRST_BIT   = 8;
  localparam int          TIMER_LAST_BIT    = 15;
  localparam int          SERIAL_FIRST_BIT  = 2;
  localparam int          SERIAL_LAST_BIT   = 7;
  localparam int          EVENT_ROUTER_BIT  = 1;
  localparam int          PROTECT_TWO_BIT   = 0;

  // ----------------------------------------------------------------------
  // Bus answers
  // ----------------------------------------------------------------------
  localparam logic [1:0]  RESP_OKAY         = 2'h0;
  localparam logic [1:0]  RESP_SLVERR       = 2'h2;

endpackage

// ==== verif/pcg_clock_gates_monitor.sv ====
`timescale 1ns/1ps
module pcg_clock_gates_monitor #(
  parameter int ADDR_W = 8
) (
  input wire logic              clock,
  input wire logic              rst_b,
  input wire logic              awvalid,
  input wire logic              awready,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic              wvalid,
  input wire logic              wready,
  input wire logic [31:0]       wdata,
  input wire logic [3:0]        wstrb,
  input wire logic              bvalid,
  input wire logic [1:0]        bresp,
  input wire logic              arvalid,
  input wire logic              arready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic              rvalid,
  input wire logic [31:0]       rdata,
  input wire logic [1:0]        rresp,
  input wire logic [0:0]        firstBridgeClk,
  input wire logic [3:0]        secondBridgeClk,
  input wire logic [19:0]       thirdBridgeClk
);
  import pcg_pkg::*;
  // --------------------------------------------------------------------
  // Handshake terms; only word-aligned addresses are expected here.
  // --------------------------------------------------------------------
  logic wrBoth;
  logic awMap;
  logic arMap;
  assign wrBoth = awvalid && awready && wvalid && wready;
  assign awMap  = awaddr inside {BRIDGE_A_MASK_OFS, BRIDGE_B_MASK_OFS, BRIDGE_C_MASK_OFS};
  assign arMap  = araddr inside {BRIDGE_A_MASK_OFS, BRIDGE_B_MASK_OFS, BRIDGE_C_MASK_OFS};
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);
  property p_b_answer;
    wrBoth |-> ##2 bvalid;
  endproperty
  a_b_answer: assert property (p_b_answer) else $error("write answer late");
  property p_r_answer;
    arvalid && arready |=> rvalid;
  endproperty
  a_r_answer: assert property (p_r_answer) else $error("read answer not one cycle late");
  property p_bad_read;
    arvalid && arready && !arMap |=> rresp == RESP_SLVERR && rdata == 32'h0;
  endproperty
  a_bad_read: assert property (p_bad_read) else $error("unmapped read not refused");
  property p_bad_write;
    wrBoth && !awMap |-> ##2 bresp == RESP_SLVERR;
  endproperty
  a_bad_write: assert property (p_bad_write) else $error("unmapped write not refused");
  // Before a rising edge every gated clock must still be low: no runt pulse.
  property p_low;
    {firstBridgeClk, secondBridgeClk, thirdBridgeClk} == 25'h0;
  endproperty
  a_low: assert property (p_low) else $error("gated clock high in low phase");
  // Falling-edge sampling sees the high phase; three cycles cover the mask register and the gate latch.
  property p_write_a;
    wrBoth && awaddr == BRIDGE_A_MASK_OFS && wstrb == 4'hf
      |-> ##3 firstBridgeClk == $past(wdata[0:0], 3);
  endproperty
  a_write_a: assert property (@(negedge clock) p_write_a)
    else $error("first bridge gate wrong");
  property p_write_b;
    wrBoth && awaddr == BRIDGE_B_MASK_OFS && wstrb == 4'hf
      |-> ##3 secondBridgeClk == $past(wdata[3:0], 3);
  endproperty
  a_write_b: assert property (@(negedge clock) p_write_b)
    else $error("second bridge gates wrong");
  property p_write_c;
    wrBoth && awaddr == BRIDGE_C_MASK_OFS && wstrb == 4'hf
      |-> ##3 thirdBridgeClk == $past(wdata[19:0], 3);
  endproperty
  a_write_c: assert property (@(negedge clock) p_write_c)
    else $error("third bridge gates wrong");
  property p_reset_vals;
    $rose(rst_b) |-> 32'(thirdBridgeClk) == (BRIDGE_C_RESET & BRIDGE_C_IMPL)
      && 32'(secondBridgeClk) == (BRIDGE_B_RESET & BRIDGE_B_IMPL);
  endproperty
  a_reset_vals: assert property (@(negedge clock) p_reset_vals)
    else $error("gates wrong after reset");
  c_write_c: cover property (wrBoth && awaddr == BRIDGE_C_MASK_OFS);
  c_bad_read: cover property (arvalid && arready && !arMap);
  c_release: cover property (@(negedge clock) $rose(rst_b));
endmodule

// ==== verif/pcg_periph_model.sv ====
`timescale 1ns/1ps
// --------------------------------------------------------------------
// Peripheral side: each module only notes that its bus clock ticked.
// --------------------------------------------------------------------
module pcg_periph_model (
  input  wire logic [24:0] gatedClk,
  input  wire logic        clr,
  output logic [24:0]      seen
);
  // A stopped clock never sets its flag, so a pulse leaking through shows up.
  for (genvar i = 0; i < 25; i++)
  begin : g_periph
    logic tick;
    always @(posedge gatedClk[i] or posedge clr)
      tick <= !clr;
    assign seen[i] = tick;
  end
endmodule

// ==== verif/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
  import pcg_pkg::*;
  // --------------------------------------------------------------------
  // Bench signals; names match the block's ports so they hook up by name.
  // --------------------------------------------------------------------
  logic        clock = 1'b0;
  logic        rst_b = 1'b0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        clr = 1'b0;
  logic [7:0]  awaddr = 8'h0, araddr = 8'h0;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'h0;
  logic [2:0]  awprot = 3'h0, arprot = 3'h0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [31:0] rdata;
  logic [1:0]  bresp, rresp;
  logic [0:0]  firstBridgeClk;
  logic [3:0]  secondBridgeClk;
  logic [19:0] thirdBridgeClk;
  logic [24:0] seen;
  int          n_mismatch = 0, checked = 0;
  pcg_clock_gates #(.ADDR_W(8)) DUT (.*);
  pcg_periph_model u_periph (
    .gatedClk({thirdBridgeClk, secondBridgeClk, firstBridgeClk}), .clr(clr), .seen(seen));
  always #5 clock = ~clock;
  task automatic check(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // One write; address and data are released each on its own acceptance.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] er);
    logic ap, wp;
    ap = 1'b1;
    wp = 1'b1;
    {awaddr, wdata, wstrb} <= {a, d, s};
    {awvalid, wvalid} <= 2'b11;
    while (ap || wp)
    begin
      @(posedge clock);
      if (awready)
        ap = 1'b0;
      if (wready)
        wp = 1'b0;
      awvalid <= ap;
      wvalid <= wp;
    end
    bready <= 1'b1;
    do
      @(posedge clock);
    while (!bvalid);
    bready <= 1'b0;
    check(32'(bresp), 32'(er));
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    {araddr, arvalid} <= {a, 1'b1};
    do
      @(posedge clock);
    while (!arready);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do
      @(posedge clock);
    while (!rvalid);
    rready <= 1'b0;
    check(rdata, ed);
    check(32'(rresp), 32'(er));
  endtask
  // Clears the peripheral flags, then lets a few gated cycles through.
  task automatic ck(input logic [24:0] e);
    clr <= 1'b1;
    @(posedge clock);
    clr <= 1'b0;
    repeat (4) @(posedge clock);
    check(32'(seen), 32'(e));
  endtask
  task automatic t_reset_vals;
    rd(BRIDGE_A_MASK_OFS, 32'h1, RESP_OKAY);
    rd(BRIDGE_B_MASK_OFS, 32'hf, RESP_OKAY);
    rd(BRIDGE_C_MASK_OFS, 32'h00010000, RESP_OKAY);
    ck({20'h10000, 4'hf, 1'b1});
  endtask
  // Walks a single one over the third mask, then sets every bit.
  task automatic t_third;
    logic [31:0] v;
    for (int i = 0; i <= 20; i++)
    begin
      v = (i == 20) ? 32'hffffffff : 32'h1 << i;
      wr(BRIDGE_C_MASK_OFS, v, 4'hf, RESP_OKAY);
      rd(BRIDGE_C_MASK_OFS, v & 32'h000fffff, RESP_OKAY);
      ck({v[19:0], 4'hf, 1'b1});
    end
  endtask
  task automatic t_second;
    wr(BRIDGE_B_MASK_OFS, 32'hfffffff5, 4'hf, RESP_OKAY);
    rd(BRIDGE_B_MASK_OFS, 32'h5, RESP_OKAY);
    wr(BRIDGE_A_MASK_OFS, 32'hfffffffe, 4'hf, RESP_OKAY);
    rd(BRIDGE_A_MASK_OFS, 32'h0, RESP_OKAY);
    ck({20'hfffff, 4'h5, 1'b0});
    wr(BRIDGE_B_MASK_OFS, 32'ha, 4'hf, RESP_OKAY);
    wr(BRIDGE_A_MASK_OFS, 32'h1, 4'hf, RESP_OKAY);
    ck({20'hfffff, 4'ha, 1'b1});
  endtask
  // Byte lane two only, then an unmapped word must change nothing.
  task automatic t_bus_edges;
    wr(BRIDGE_C_MASK_OFS, 32'h000a0000, 4'h4, RESP_OKAY);
    rd(BRIDGE_C_MASK_OFS, 32'h000affff, RESP_OKAY);
    wr(8'h24, 32'h0, 4'hf, RESP_SLVERR);
    rd(8'h24, 32'h0, RESP_SLVERR);
    rd(BRIDGE_C_MASK_OFS, 32'h000affff, RESP_OKAY);
  endtask
  task automatic t_rereset;
    wr(BRIDGE_A_MASK_OFS, 32'h0, 4'hf, RESP_OKAY);
    wr(BRIDGE_B_MASK_OFS, 32'h0, 4'hf, RESP_OKAY);
    wr(BRIDGE_C_MASK_OFS, 32'h0, 4'hf, RESP_OKAY);
    rst_b <= 1'b0;
    repeat (12) @(posedge clock);
    rst_b <= 1'b1;
    t_reset_vals();
  endtask
  task automatic tally_and_finish;
    if (n_mismatch == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    repeat (12) @(posedge clock);
    rst_b <= 1'b1;
    t_reset_vals();
    t_third();
    t_second();
    t_bus_edges();
    t_rereset();
    tally_and_finish();
  end
  // The whole run needs well under a thousand cycles.
  initial
  begin
    repeat (5000) @(posedge clock);
    n_mismatch++;
    tally_and_finish();
  end
endmodule
bind pcg_clock_gates pcg_clock_gates_monitor #(.ADDR_W(ADDR_W)) u_mon (.*);
